// [rtl/ddrcm_top.sv]
// command decode, bank tracking and mode register of a ddr2 device
// assumes command pins already registered to clk_in; tiny array model
`timescale 1ns/1ps
// How it works
// - chip select high ignores new commands
// - nop registers nothing, work continues
// - bank bits pick mode register, address loads
// - activate opens row until precharged
// - column command gives bank, column, a10
// - auto precharge closes row after burst
// - column commands delayed by additive latency
// - masked write bytes leave array unchanged
// - precharge one or all banks, wait
// - precharge accepted anytime, timer restarts
// - other banks usable during auto precharge
// - refresh rows come from internal counter
// - refresh with clock enable low self-refreshes
// - dll off in self refresh, on after
// - mode kept; dll reset bit self-clears
// - burst length four or eight, both directions
// - burst wraps inside aligned column block
// - order bit picks sequential or interleaved
// - read latency field sets data delay
// - control pins decode to commands
module ddrcm_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [2:0] ba_in,
    input wire logic [13:0] addr_in,
    input wire logic [2:0] posted_additive_latency_in,
    input wire logic wvalid_in,
    input wire logic [7:0] wdata_in,
    input wire logic wdm_in,
    output logic wready_out,
    output logic rvalid_out,
    output logic [7:0] rdata_out,
    output logic [12:0] main_mode_register_out,
    output logic dll_on_out,
    output logic self_refresh_out,
    output logic refresh_out,
    output logic [13:0] refresh_row_out,
    output logic cmd_reject_out
);
    // =====================================
    // decode
    ddrcm_pkg::ddrcm_cmd_e cmd; // decoded command
    ddrcm_pkg::ddrcm_bank_e bank_st_reg [8]; // per bank state
    logic [3:0] bank_tmr_reg [8]; // precharge period count
    logic [13:0] bank_row_reg [8]; // open row per bank
    logic [12:0] mode_reg; // main_mode_register
    logic sel, all_idle, legal, sr_entry;
    assign sel = !cs_n_in & cke_in & !self_refresh_out;
    always_comb begin
        case ({ras_n_in, cas_n_in, we_n_in})
            3'b011: cmd = ddrcm_pkg::C_ACT;
            3'b101: cmd = ddrcm_pkg::C_RD;
            3'b100: cmd = ddrcm_pkg::C_WR;
            3'b010: cmd = ddrcm_pkg::C_PRE;
            3'b000: cmd = ddrcm_pkg::C_MODE;
            3'b001: cmd = ddrcm_pkg::C_REF;
            default: cmd = ddrcm_pkg::C_NOP;
        endcase
    end
    // burst engine state, declared early for idle check
    logic busy_reg, bwr_reg, bap_reg;
    logic [2:0] bba_reg, bcol_reg, beat_reg, lat_reg;
    always_comb begin
        all_idle = !busy_reg;
        for (int b = 0; b < 8; b++) begin
            if (bank_st_reg[b] != ddrcm_pkg::BK_IDLE) all_idle = 1'b0;
        end
    end
    // legality against addressed bank state; mode and refresh need all banks idle
    always_comb begin
        case (cmd)
            ddrcm_pkg::C_ACT: legal = (bank_st_reg[ba_in] == ddrcm_pkg::BK_IDLE);
            ddrcm_pkg::C_RD, ddrcm_pkg::C_WR: legal = (bank_st_reg[ba_in] inside
                {ddrcm_pkg::BK_ACT, ddrcm_pkg::BK_RD, ddrcm_pkg::BK_WR}); // per bank
            ddrcm_pkg::C_MODE, ddrcm_pkg::C_REF: legal = all_idle;
            default: legal = 1'b1; // precharge and nop always taken
        endcase
    end
    // refresh pattern with clock enable low enters self refresh
    assign sr_entry = !cs_n_in & !cke_in & !self_refresh_out & (cmd == ddrcm_pkg::C_REF)
        & all_idle;
    // =====================================
    // posted additive latency pipe; stage 0 issues to the engine
    logic pv_reg [8];
    logic pw_reg [8];
    logic pap_reg [8];
    logic [2:0] pba_reg [8];
    logic [2:0] pcol_reg [8];
    logic col_take;
    assign col_take = sel & legal & (cmd inside {ddrcm_pkg::C_RD, ddrcm_pkg::C_WR});
    // later stage slides down each cycle; a new command lands at the chosen depth
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < 8; i++) begin
                pv_reg[i] <= 1'b0;
                pw_reg[i] <= 1'b0;
                pap_reg[i] <= 1'b0;
                pba_reg[i] <= 3'h0;
                pcol_reg[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 7; i++) begin
                pv_reg[i] <= pv_reg[i+1];
                pw_reg[i] <= pw_reg[i+1];
                pap_reg[i] <= pap_reg[i+1];
                pba_reg[i] <= pba_reg[i+1];
                pcol_reg[i] <= pcol_reg[i+1];
            end
            pv_reg[7] <= 1'b0;
            if (col_take) begin
                pv_reg[posted_additive_latency_in] <= 1'b1;
                pw_reg[posted_additive_latency_in] <= (cmd == ddrcm_pkg::C_WR);
                pap_reg[posted_additive_latency_in] <= addr_in[ddrcm_pkg::AP_BIT];
                pba_reg[posted_additive_latency_in] <= ba_in;
                pcol_reg[posted_additive_latency_in] <= addr_in[2:0];
            end
        end
    end
    // =====================================
    // burst engine; only the low column bits are modelled
    logic bl8, il, beat_go, last;
    logic [2:0] ccol;
    logic [8:0] fdata;
    logic fvalid;
    assign bl8 = (mode_reg[ddrcm_pkg::BL_LSB +: 3] == ddrcm_pkg::BL_EIGHT);
    assign il = mode_reg[ddrcm_pkg::ORDER_BIT];
    // beat column inside the aligned block
    function automatic logic [2:0] bcol(input logic [2:0] s, input logic [2:0] i,
        input logic b8, input logic inter);
        logic [2:0] r;
        r = inter ? (s ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]};
        if (!b8) r[2] = s[2]; // block picked by upper bits
        return r;
    endfunction
    assign ccol = bcol(bcol_reg, beat_reg, bl8, il);
    // writes stall on an empty buffer, reads wait out the latency
    assign beat_go = busy_reg & (bwr_reg ? fvalid : (lat_reg == 3'h0));
    assign last = (beat_reg == (bl8 ? 3'h7 : 3'h3));
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_reg <= 1'b0;
            bwr_reg <= 1'b0;
            bap_reg <= 1'b0;
            bba_reg <= 3'h0;
            bcol_reg <= 3'h0;
            beat_reg <= 3'h0;
            lat_reg <= 3'h0;
        end else if (pv_reg[0]) begin // new burst replaces the old one
            busy_reg <= 1'b1;
            bwr_reg <= pw_reg[0];
            bap_reg <= pap_reg[0];
            bba_reg <= pba_reg[0];
            bcol_reg <= pcol_reg[0];
            beat_reg <= 3'h0;
            // engine load and output flop each cost a clock, hence latency minus two
            lat_reg <= pw_reg[0] ? 3'h0 : mode_reg[ddrcm_pkg::CL_LSB +: 3] - 3'h2;
        end else if (busy_reg) begin
            if (!bwr_reg && lat_reg != 3'h0) lat_reg <= lat_reg - 3'h1;
            if (beat_go) begin
                beat_reg <= beat_reg + 3'h1;
                if (last) busy_reg <= 1'b0;
            end
        end
    end
    // =====================================
    // write buffer and array
    ddrcm_fifo #(.W(9), .D(ddrcm_pkg::FIFO_DEPTH)) u_wbuf (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(wvalid_in),
        .in_data_in({wdm_in, wdata_in}),
        .in_ready_out(wready_out),
        .out_valid_out(fvalid),
        .out_data_out(fdata),
        .out_ready_in(busy_reg & bwr_reg & !pv_reg[0])
    );
    logic [7:0] mem [64]; // byte per bank and low column
    logic wr_en;
    assign wr_en = beat_go & bwr_reg & !pv_reg[0] & !fdata[8];
    // array keeps its data over mode loads, so no reset
    always_ff @(posedge clk_in) begin
        if (wr_en) mem[{bba_reg, ccol}] <= fdata[7:0];
    end
    // read data leaves as one beat per cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= 8'h00;
        end else begin
            rvalid_out <= beat_go & !bwr_reg & !pv_reg[0];
            rdata_out <= mem[{bba_reg, ccol}];
        end
    end
    // =====================================
    // bank states
    logic bend;
    assign bend = beat_go & last & !pv_reg[0];
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int b = 0; b < 8; b++) begin
                bank_st_reg[b] <= ddrcm_pkg::BK_IDLE;
                bank_tmr_reg[b] <= 4'h0;
                bank_row_reg[b] <= 14'h0000;
            end
        end else begin
            for (int b = 0; b < 8; b++) begin
                if (bank_st_reg[b] == ddrcm_pkg::BK_PRE) begin
                    if (bank_tmr_reg[b] <= 4'h1) bank_st_reg[b] <= ddrcm_pkg::BK_IDLE;
                    else bank_tmr_reg[b] <= bank_tmr_reg[b] - 4'h1;
                end
            end
            if (pv_reg[0]) begin // burst starts at issue
                bank_st_reg[pba_reg[0]] <= pw_reg[0] ? ddrcm_pkg::BK_WR : ddrcm_pkg::BK_RD;
            end else if (bend) begin
                if (bap_reg) begin // close row after burst
                    bank_st_reg[bba_reg] <= ddrcm_pkg::BK_PRE;
                    bank_tmr_reg[bba_reg] <= 4'(ddrcm_pkg::PRE_CYC);
                end else begin
                    bank_st_reg[bba_reg] <= ddrcm_pkg::BK_ACT;
                end
            end
            if (sel && legal && cmd == ddrcm_pkg::C_ACT) begin
                bank_st_reg[ba_in] <= ddrcm_pkg::BK_ACT;
                bank_row_reg[ba_in] <= addr_in;
            end
            if (sel && cmd == ddrcm_pkg::C_PRE) begin // timer from latest
                for (int b = 0; b < 8; b++) begin
                    if (addr_in[ddrcm_pkg::AP_BIT] || ba_in == 3'(b)) begin
                        bank_st_reg[b] <= ddrcm_pkg::BK_PRE;
                        bank_tmr_reg[b] <= 4'(ddrcm_pkg::PRE_CYC);
                    end
                end
            end
        end
    end
    // =====================================
    // mode register, refresh, self refresh, reject flag
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_reg <= ddrcm_pkg::MODE_RST;
        end else if (sel && legal && cmd == ddrcm_pkg::C_MODE
            && ba_in == ddrcm_pkg::MAIN_MR_SEL) begin
            mode_reg <= addr_in[12:0];
        end else begin
            mode_reg[ddrcm_pkg::DLL_RST_BIT] <= 1'b0; // self-clearing
        end
    end
    assign main_mode_register_out = mode_reg;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            refresh_out <= 1'b0;
            refresh_row_out <= 14'h0000;
            self_refresh_out <= 1'b0;
            dll_on_out <= 1'b1;
            cmd_reject_out <= 1'b0;
        end else begin
            refresh_out <= sel & legal & (cmd == ddrcm_pkg::C_REF);
            if (sel && legal && cmd == ddrcm_pkg::C_REF) begin
                refresh_row_out <= refresh_row_out + 14'h0001;
            end
            if (sr_entry) begin
                self_refresh_out <= 1'b1;
                dll_on_out <= 1'b0;
            end else if (self_refresh_out && cke_in) begin
                self_refresh_out <= 1'b0;
                dll_on_out <= 1'b1;
            end
            cmd_reject_out <= sel & !legal;
        end
    end
    // =====================================
    // checks
    property p_desel;
        @(posedge clk_in) disable iff (!nrst_in) cs_n_in |=> !refresh_out && !cmd_reject_out;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect took a command");
    property p_nop;
        @(posedge clk_in) disable iff (!nrst_in)
            sel && cmd == ddrcm_pkg::C_NOP |=> $stable(refresh_row_out) && !cmd_reject_out;
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    property p_mload;
        @(posedge clk_in) disable iff (!nrst_in)
            sel && legal && cmd == ddrcm_pkg::C_MODE && ba_in == 3'h0
            |=> mode_reg[7:0] == $past(addr_in[7:0]);
    endproperty
    a_mload: assert property (p_mload) else $error("mode load lost");
    property p_dllclr;
        @(posedge clk_in) disable iff (!nrst_in) mode_reg[8] |=> !mode_reg[8];
    endproperty
    a_dllclr: assert property (p_dllclr) else $error("dll reset bit stuck");
    property p_sref;
        @(posedge clk_in) disable iff (!nrst_in)
            sr_entry |=> self_refresh_out && !dll_on_out ##1 !refresh_out;
    endproperty
    a_sref: assert property (p_sref) else $error("self refresh entry wrong");
    property p_refrow;
        @(posedge clk_in) disable iff (!nrst_in)
            sel && legal && cmd == ddrcm_pkg::C_REF
            |=> refresh_row_out == $past(refresh_row_out) + 14'h0001;
    endproperty
    a_refrow: assert property (p_refrow) else $error("refresh row not advanced");
    property p_mask;
        @(posedge clk_in) disable iff (!nrst_in)
            beat_go && bwr_reg && !pv_reg[0] && fdata[8]
            |=> mem[$past({bba_reg, ccol})] == $past(mem[{bba_reg, ccol}]);
    endproperty
    a_mask: assert property (p_mask) else $error("masked byte written");
    property p_pre;
        @(posedge clk_in) disable iff (!nrst_in)
            sel && cmd == ddrcm_pkg::C_PRE |=> bank_st_reg[$past(ba_in)] == ddrcm_pkg::BK_PRE;
    endproperty
    a_pre: assert property (p_pre) else $error("precharge not taken");
endmodule

// [rtl/ddrcm_pkg.sv]
// constants for the ddr2 command and mode decode block
// assumes a 10 mhz core clock and one x8 device slice
package ddrcm_pkg;
    // =====================================
    // clock and timing
    localparam int CLK_MHZ = 10; // core clock rate
    localparam int PRECHARGE_PERIOD_NS = 15; // least precharge period
    // least time, rounded up, never below one cycle
    localparam int PRE_CYC_RAW = (PRECHARGE_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int PRE_CYC = (PRE_CYC_RAW < 1) ? 1 : PRE_CYC_RAW;
    // =====================================
    // widths
    localparam int BANKS = 8; // bank count
    localparam int BA_W = 3; // bank address width
    localparam int ADDR_W = 14; // address bus width
    localparam int DATA_W = 8; // data byte width
    localparam int FIFO_DEPTH = 16; // write data buffer words
    localparam int MODE_W = 13; // writable mode bits
    localparam int AL_STAGES = 8; // posted latency pipe depth
    // =====================================
    // main mode register fields
    localparam int BL_LSB = 0; // burst_length_field low bit
    localparam int ORDER_BIT = 3; // burst_order_bit
    localparam int CL_LSB = 4; // read_latency_field low bit
    localparam int DLL_RST_BIT = 8; // dll_reset_bit
    localparam int AP_BIT = 10; // auto precharge address bit
    localparam logic [2:0] BL_FOUR = 3'h2; // burst_len 4 code
    localparam logic [2:0] BL_EIGHT = 3'h3; // burst_len 8 code
    localparam logic [12:0] MODE_RST = 13'h0032; // length four, latency three
    localparam logic [2:0] MAIN_MR_SEL = 3'h0; // bank code of main_mode_register
    // =====================================
    // types
    typedef enum logic [2:0] {BK_IDLE, BK_ACT, BK_RD, BK_WR, BK_PRE} ddrcm_bank_e;
    typedef enum logic [2:0] {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_MODE, C_REF} ddrcm_cmd_e;
endpackage

// [rtl/ddrcm_fifo.sv]
// write data buffer with valid and ready on both sides
// assumes depth is a power of two
`timescale 1ns/1ps
module ddrcm_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D]; // storage
    logic [AW-1:0] wr_ptr_reg, rd_ptr_reg; // wrap naturally
    logic [AW:0] cnt_reg, cnt_next; // fill level
    logic push, pop;
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_valid_out = (cnt_reg != '0);
    assign out_data_out = mem[rd_ptr_reg];
    assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // =====================================
    // pointers and level; ready is a flop so full is honest
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            in_ready_out <= 1'b0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            cnt_reg <= cnt_next;
            in_ready_out <= (cnt_next != (AW+1)'(D));
        end
    end
    // storage, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) mem[wr_ptr_reg] <= in_data_in;
    end
endmodule

// [verification/ddrcm_ctl_model.sv]
// controller model: drives command, bank, address and write data pins
// assumes the device samples every pin on the rising edge of clk_in
`timescale 1ns/1ps
module ddrcm_ctl_model (
    input wire logic clk_in,
    input wire logic wready_in,
    output logic cke_out,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [2:0] ba_out,
    output logic [13:0] addr_out,
    output logic wvalid_out,
    output logic [7:0] wdata_out,
    output logic wdm_out
);
    // ========================================
    // state
    int fails = 0; // pushes that never found room
    // quiet bus at time zero, device deselected
    initial begin
        cke_out = 1'b1;
        cs_n_out = 1'b1;
        {ras_n_out, cas_n_out, we_n_out} = 3'h7;
        ba_out = 3'h0;
        addr_out = 14'h0000;
        wvalid_out = 1'b0;
        wdata_out = 8'h00;
        wdm_out = 1'b0;
    end
    // ========================================
    // command bus
    // one command for one edge, then deselect with flipped lines so stale
    // values never look valid; mode loads only go out with all banks idle,
    // refresh also with a bank open; mode loads carry every field reserved
    // bits zero; writes follow an activate, reads also go to closed banks
    task automatic cmd(input logic cs_n, input logic [2:0] rcw, input logic [2:0] ba,
                       input logic [13:0] addr, input logic cke);
        @(posedge clk_in);
        #1;
        cke_out = cke;
        cs_n_out = cs_n;
        {ras_n_out, cas_n_out, we_n_out} = rcw;
        ba_out = ba;
        addr_out = addr;
        @(posedge clk_in);
        #1;
        cs_n_out = 1'b1;
        {ras_n_out, cas_n_out, we_n_out} = ~rcw;
        ba_out = ~ba;
        addr_out = ~addr;
    endtask
    // clock enable change, used to leave self refresh
    task automatic set_cke(input logic v);
        @(posedge clk_in);
        #1;
        cke_out = v;
    endtask
    // ========================================
    // write data
    // hold byte until an edge sees ready; bounded so a full buffer cannot hang
    task automatic push(input logic [7:0] data, input logic dm);
        int n;
        @(posedge clk_in);
        #1;
        wvalid_out = 1'b1;
        wdata_out = data;
        wdm_out = dm;
        n = 0;
        @(negedge clk_in);
        while (wready_in !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        if (wready_in !== 1'b1) fails++; // still full when the bound ran out
        @(posedge clk_in);
        #1;
        wvalid_out = 1'b0;
        wdata_out = ~data;
        wdm_out = ~dm;
    endtask
endmodule

// [verification/tb_top.sv]
// testbench for the ddr2 command and mode decode block
// assumes a 100 ns clock; controller model drives command and data pins
`timescale 1ns/1ps
module tb_top;
    // ========================================
    // signals
    localparam logic [2:0] K_ACT = 3'h3, K_RD = 3'h5, K_WR = 3'h4, K_PRE = 3'h2;
    localparam logic [2:0] K_MRS = 3'h0, K_REF = 3'h1, K_NOP = 3'h7;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [2:0] al = 3'h0; // additive latency
    logic cke, cs_n, ras_n, cas_n, we_n, wvalid, wdm, wready, rvalid, dll_on, sref, refr, rej;
    logic [2:0] ba;
    logic [13:0] addr, ref_row;
    logic [7:0] wdata, rdata;
    logic [12:0] mode;
    int bad_count = 0, checks_done = 0, cyc = 0, rej_cnt = 0, ref_cnt = 0, first_cyc = 0;
    logic [7:0] rq [$]; // read beats seen
    logic [7:0] e4 [8] = '{0: 8'h11, 1: 8'ha2, 2: 8'ha3, 3: 8'ha0, default: 8'h00};
    logic [7:0] e0 [8] = '{0: 8'ha0, 1: 8'h11, 2: 8'ha2, 3: 8'ha3, default: 8'h00};
    logic [7:0] eq [8] = '{8'h2d, 8'h2e, 8'h2f, 8'h2c, 8'h29, 8'h2a, 8'h2b, 8'h28};
    // ========================================
    // parts
    ddrcm_ctl_model ddrcm_ctl_model_i (.clk_in(clk_in), .wready_in(wready), .cke_out(cke),
        .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba),
        .addr_out(addr), .wvalid_out(wvalid), .wdata_out(wdata), .wdm_out(wdm));
    ddrcm_top ddrcm_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .cke_in(cke), .cs_n_in(cs_n),
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
        .posted_additive_latency_in(al), .wvalid_in(wvalid), .wdata_in(wdata), .wdm_in(wdm),
        .wready_out(wready), .rvalid_out(rvalid), .rdata_out(rdata),
        .main_mode_register_out(mode), .dll_on_out(dll_on), .self_refresh_out(sref),
        .refresh_out(refr), .refresh_row_out(ref_row), .cmd_reject_out(rej));
    // ========================================
    // clock and monitors
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc++;
    // pulses and beats sampled mid-cycle, where registered outputs are settled
    always @(negedge clk_in) begin
        if (rej === 1'b1) rej_cnt++;
        if (refr === 1'b1) ref_cnt++;
        if (rvalid === 1'b1) begin
            if (rq.size() == 0) first_cyc = cyc;
            rq.push_back(rdata);
        end
    end
    // ========================================
    // helpers
    task automatic final_report();
        bad_count += ddrcm_ctl_model_i.fails;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_val(input string what, input logic [13:0] exp, input logic [13:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one command, then the count of refusals it caused
    task automatic cmd_rej(input logic [2:0] rcw, input logic [2:0] b, input logic [13:0] a,
                           input int exp);
        int r0;
        r0 = rej_cnt;
        ddrcm_ctl_model_i.cmd(1'b0, rcw, b, a, 1'b1);
        idle(3);
        cmp_val("reject", 14'(exp), 14'(rej_cnt - r0));
    endtask
    // read burst: beat count, order and latency from the command edge
    task automatic rd_check(input logic [2:0] b, input logic [13:0] a, input int n,
                            input logic [7:0] e [8], input int lat);
        int c0;
        int k;
        rq.delete();
        ddrcm_ctl_model_i.cmd(1'b0, K_RD, b, a, 1'b1);
        c0 = cyc;
        k = 0;
        while (rq.size() < n && k < 40) begin
            idle(1);
            k++;
        end
        if (k == 40) begin
            bad_count++;
            final_report();
        end
        idle(4); // extra beats would show here
        cmp_val("beats", 14'(n), 14'(rq.size()));
        for (int i = 0; i < n; i++) cmp_val("rdata", {6'h00, e[i]}, {6'h00, rq[i]});
        cmp_val("latency", 14'(lat), 14'(first_cyc - c0));
    endtask
    task automatic wr(input logic [2:0] b, input logic [13:0] a);
        ddrcm_ctl_model_i.cmd(1'b0, K_WR, b, a, 1'b1);
        idle(16); // burst pulls its beats out of the buffer
    endtask
    // ========================================
    // scenarios
    task automatic t_reset();
        cmp_val("mode", 14'h0032, {1'b0, mode});
        cmp_val("dll", 14'h0001, {13'h0, dll_on});
        cmp_val("sref", 14'h0000, {13'h0, sref});
        $display("reset test done");
    endtask
    // masked byte keeps old data; wrapped read from column one
    task automatic t_wr_rd();
        for (int i = 0; i < 4; i++) ddrcm_ctl_model_i.push(8'(8'h10 + i), 1'b0);
        cmd_rej(K_ACT, 3'h1, 14'h0005, 0);
        wr(3'h1, 14'h0000);
        for (int i = 0; i < 4; i++) ddrcm_ctl_model_i.push(8'(8'ha0 + i), i == 1);
        wr(3'h1, 14'h0000);
        rd_check(3'h1, 14'h0001, 4, e4, 3);
        $display("write read test done");
    endtask
    task automatic t_select();
        ddrcm_ctl_model_i.cmd(1'b1, K_ACT, 3'h3, 14'h0007, 1'b1);
        cmd_rej(K_NOP, 3'h3, 14'h0007, 0);
        cmd_rej(K_RD, 3'h3, 14'h0000, 1);
        cmd_rej(K_ACT, 3'h1, 14'h0009, 1);
        $display("select test done");
    endtask
    task automatic t_pre();
        rd_check(3'h1, 14'h0000, 4, e0, 3);
        cmd_rej(K_ACT, 3'h1, 14'h0009, 1);
        rd_check(3'h1, 14'h0400, 4, e0, 3);
        cmd_rej(K_ACT, 3'h1, 14'h0009, 0);
        cmd_rej(K_PRE, 3'h1, 14'h0000, 0);
        cmd_rej(K_PRE, 3'h1, 14'h0000, 0);
        cmd_rej(K_RD, 3'h1, 14'h0000, 1);
        cmd_rej(K_ACT, 3'h1, 14'h0005, 0);
        al = 3'h3;
        rd_check(3'h1, 14'h0000, 4, e0, 6);
        al = 3'h0;
        $display("precharge test done");
    endtask
    task automatic t_mode();
        int r0;
        cmd_rej(K_PRE, 3'h0, 14'h0400, 0);
        cmd_rej(K_MRS, 3'h0, 14'h014b, 0);
        cmp_val("mode", 14'h004b, {1'b0, mode});
        cmd_rej(K_MRS, 3'h1, 14'h0000, 0);
        cmp_val("mode", 14'h004b, {1'b0, mode});
        r0 = ref_cnt;
        cmd_rej(K_REF, 3'h0, 14'h1234, 0);
        cmd_rej(K_REF, 3'h5, 14'h0777, 0);
        cmp_val("refresh", 14'h0002, 14'(ref_cnt - r0));
        cmp_val("row", 14'h0002, ref_row);
        cmd_rej(K_ACT, 3'h4, 14'h0000, 0);
        cmd_rej(K_REF, 3'h0, 14'h0000, 1);
        $display("mode test done");
    endtask
    // fill buffer until refused, drain by two long bursts
    task automatic t_fifo();
        logic [7:0] ei [8] = '{8'h2d, 8'h2c, 8'h2f, 8'h2e, 8'h29, 8'h28, 8'h2b, 8'h2a};
        for (int i = 0; i < 16; i++) ddrcm_ctl_model_i.push(8'(8'h20 + i), 1'b0);
        idle(2);
        cmp_val("wready", 14'h0000, {13'h0, wready});
        cmd_rej(K_ACT, 3'h2, 14'h0003, 0);
        wr(3'h2, 14'h0000);
        wr(3'h2, 14'h0000);
        cmp_val("wready", 14'h0001, {13'h0, wready});
        rd_check(3'h2, 14'h0005, 8, ei, 4);
        cmd_rej(K_PRE, 3'h0, 14'h0400, 0);
        cmd_rej(K_MRS, 3'h0, 14'h0033, 0);
        cmd_rej(K_ACT, 3'h2, 14'h0003, 0);
        rd_check(3'h2, 14'h0005, 8, eq, 3);
        $display("buffer test done");
    endtask
    task automatic t_self();
        cmd_rej(K_PRE, 3'h0, 14'h0400, 0);
        ddrcm_ctl_model_i.cmd(1'b0, K_REF, 3'h0, 14'h0000, 1'b0);
        idle(2);
        cmp_val("sref", 14'h0001, {13'h0, sref});
        cmp_val("dll", 14'h0000, {13'h0, dll_on});
        ddrcm_ctl_model_i.set_cke(1'b1);
        idle(3);
        cmp_val("sref", 14'h0000, {13'h0, sref});
        cmp_val("dll", 14'h0001, {13'h0, dll_on});
        cmd_rej(K_ACT, 3'h2, 14'h0003, 0);
        rd_check(3'h2, 14'h0005, 8, eq, 3);
        $display("self refresh test done");
    endtask
    // ========================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        idle(3);
        t_reset();
        t_wr_rd();
        t_select();
        t_pre();
        t_mode();
        t_fifo();
        t_self();
        final_report();
    end
endmodule
